// ==== slcd_frame_timer.sv ====
// divider producing the common step enable for the chosen frame rate
module slcd_frame_timer #(
    parameter int CNT_W    = 24,
    parameter int DIV_BASE = slcd_pkg::FRAME_DIV_BASE
) (
    input  wire logic    mclk_i,  // system clock
    input  wire logic    nrst_i,  // async reset, active low
    slcd_tick_if.timer   tick     // run, select and step
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] limit;
    logic [3:0]       sel_eff;
    logic             step_q;
    logic             hit;

    // eleven rates, out-of-range codes take the slowest
    assign sel_eff = (tick.freq_sel > slcd_pkg::FREQ_SEL_MAX) ?
                     slcd_pkg::FREQ_SEL_MAX : tick.freq_sel;
    assign limit = (CNT_W'(1) << (CNT_W'(sel_eff) + CNT_W'(DIV_BASE)))
                   - CNT_W'(1);
    assign hit   = tick.run && (cnt_q >= limit); // rate cut mid-count
    assign cnt_d = (!tick.run || hit) ? '0 : cnt_q + CNT_W'(1);
    assign tick.step = step_q;

    // counter and registered step pulse
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q  <= '0;
            step_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            step_q <= hit;
        end
    end
endmodule : slcd_frame_timer

// ==== slcd_glass_model.sv ====
// observer standing in for the lcd glass panel
module slcd_glass_model (
    input  wire logic             mclk_i,    // clock
    input  wire logic             nrst_i,    // reset
    input  wire logic [3:0][1:0]  com_lvl_i, // common levels
    input  wire logic [24:0][1:0] seg_lvl_i, // segment levels
    output int                    edges_o,   // first common changes
    output int                    gap_o      // cycles between changes
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] prev_q; // last first-common level
    int         run_q;  // cycles since last change
    // time the steps seen on the first backplane
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_q  <= 2'h0;
            run_q   <= 0;
            edges_o <= 0;
            gap_o   <= 0;
        end else begin
            prev_q <= com_lvl_i[0];
            run_q  <= (com_lvl_i[0] != prev_q) ? 0 : run_q + 1;
            if (com_lvl_i[0] != prev_q) begin
                edges_o <= edges_o + 1;
                gap_o   <= run_q + 1;
            end
        end
    end
endmodule : slcd_glass_model

// ==== slcd_pkg.sv ====
// shared constants for the segment lcd port and duty configuration block
package slcd_pkg;
    // register bus and pin geometry
    localparam int ADDR_W   = 5;
    localparam int DATA_W   = 16;
    localparam int NUM_COM  = 4;
    localparam int NUM_SEG  = 25;
    localparam int NUM_GRP  = 7;     // six four-pin groups plus top pin
    localparam int MEM_BYTES = 13;

    // register offsets (byte addresses)
    localparam logic [4:0] OFF_PIN_DUTY_CFG = 5'h00;
    localparam logic [4:0] OFF_DRIVE_CTRL   = 5'h01;
    localparam logic [4:0] OFF_MOD_STANDBY  = 5'h02;
    localparam logic [4:0] OFF_DISP_MEM     = 5'h10;

    // pin/duty config fields
    localparam int DUTY_HI_POS = 7;
    localparam int DUTY_LO_POS = 6;
    localparam int MIRROR_POS  = 5;
    localparam int RSVD_POS    = 4;
    localparam int SGS_MSB     = 3;

    // drive control and module standby fields
    localparam int FREQ_MSB     = 3;
    localparam int WAVE_B_POS   = 4;
    localparam int DISP_ON_POS  = 5;
    localparam int MSTOP_POS    = 0;

    // reset values
    localparam logic [7:0] RST_PIN_DUTY_CFG = 8'h00;
    localparam logic [7:0] RST_DRIVE_CTRL   = 8'h00;
    localparam logic [7:0] RST_MOD_STANDBY  = 8'h00;
    localparam logic [7:0] RST_DISP_MEM     = 8'h00;

    // segment group select special codes
    localparam logic [3:0] SGS_ALL_DRV  = 4'h8;
    localparam logic [3:0] SGS_ALL_PORT = 4'hf;

    // frame frequency choices: codes 0 to 10
    localparam logic [3:0] FREQ_SEL_MAX = 4'ha;
    localparam int FRAME_DIV_BASE       = 6;

    // drive level codes, vss lowest to v1 highest
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_V3  = 2'h1;
    localparam logic [1:0] LVL_V2  = 2'h2;
    localparam logic [1:0] LVL_V1  = 2'h3;

    typedef enum logic [1:0] {
        DUTY_STATIC,
        DUTY_HALF,
        DUTY_THIRD,
        DUTY_QUARTER
    } slcd_duty_t;
endpackage : slcd_pkg

// ==== slcd_tick_if.sv ====
// step-rate handshake between drive control and frame timer
interface slcd_tick_if;
    logic       run;       // timer may count
    logic [3:0] freq_sel;  // frame frequency code
    logic       step;      // one-cycle common step enable

    modport timer (input run, input freq_sel, output step);
    modport ctrl  (output run, output freq_sel, input step);
endinterface : slcd_tick_if

// ==== slcd_top.sv ====
// segment lcd pin allocation, duty, display memory and drive levels
//
// Summary of operation
// - duty code: static, half, third, quarter
// - static, no mirror: only first common driven
// - static, mirror: commons two-four copy common one
// - half duty, no mirror: commons one, two
// - half mirror: four copies three, two copies one
// - mirroring only static/half; third leaves four unused
// - four-bit group select picks segment drivers
// - lower 24 segment pins switch by fours
// - display memory of thirteen eight-bit bytes
// - display memory accepts word and byte accesses
// - eleven selectable frame frequencies
// - software chooses waveform A or B
// - display runs while switched on, except in chip standby or module standby
// - module standby stops block alone
// - select codes map groups to drivers/ports
//
// Decided for this implementation: the strobed register port and the register offsets.
module slcd_top #(
    parameter int CNT_W    = 24,                       // divider width
    parameter int DIV_BASE = slcd_pkg::FRAME_DIV_BASE  // fastest divide
) (
    input  wire logic                        mclk_i,    // system clock
    input  wire logic                        nrst_i,    // async reset
    input  wire logic [slcd_pkg::ADDR_W-1:0] addr_i,    // byte address
    input  wire logic [slcd_pkg::DATA_W-1:0] wdata_i,   // write data
    input  wire logic                        wr_i,      // write strobe
    input  wire logic                        rd_i,      // read strobe
    input  wire logic                        word_i,    // word access
    input  wire logic                        standby_i, // chip standby
    output logic      [slcd_pkg::DATA_W-1:0] rdata_o,   // read data
    output logic [slcd_pkg::NUM_COM-1:0][1:0] com_lvl_o, // common levels
    output logic      [slcd_pkg::NUM_COM-1:0] com_used_o, // common active
    output logic [slcd_pkg::NUM_SEG-1:0][1:0] seg_lvl_o, // segment levels
    output logic      [slcd_pkg::NUM_SEG-1:0] seg_drv_o  // 1 lcd, 0 port
);
    localparam int NC = slcd_pkg::NUM_COM;
    localparam int NS = slcd_pkg::NUM_SEG;
    localparam int NB = slcd_pkg::MEM_BYTES;

    // configuration registers
    logic [1:0] duty_q;
    logic       backplane_mirror_enable_q;
    logic [3:0] segment_group_select_q;
    logic [3:0] freq_sel_q;
    logic       wave_b_q;
    logic       disp_on_q;
    logic       mstop_q;
    logic [7:0] display_memory_q [NB];

    // drive sequencing state
    logic [1:0] line_q;
    logic       pol_q;
    logic       run;
    logic       line_wrap;
    slcd_pkg::slcd_duty_t duty;

    // output registers
    logic [slcd_pkg::DATA_W-1:0] rdata_q;
    logic [NC-1:0][1:0]          com_lvl_q;
    logic [NC-1:0]               com_used_q;
    logic [NS-1:0][1:0]          seg_lvl_q;
    logic [NS-1:0]               seg_drv_q;

    // bus decode
    logic       hit_cfg;
    logic       hit_ctrl;
    logic       hit_mstby;
    logic       hit_mem;
    logic [3:0] mem_idx;
    logic [3:0] mem_even;
    logic [3:0] mem_odd;
    logic [7:0] mem_rd_hi;
    logic [7:0] mem_rd_lo;
    logic [7:0] cfg_rd;
    logic [7:0] ctrl_rd;
    logic [slcd_pkg::DATA_W-1:0] rd_d;

    assign hit_cfg   = (addr_i == slcd_pkg::OFF_PIN_DUTY_CFG);
    assign hit_ctrl  = (addr_i == slcd_pkg::OFF_DRIVE_CTRL);
    assign hit_mstby = (addr_i == slcd_pkg::OFF_MOD_STANDBY);
    assign hit_mem   = (addr_i >= slcd_pkg::OFF_DISP_MEM) &&
                       (addr_i < slcd_pkg::OFF_DISP_MEM + 5'(NB));
    assign mem_idx   = 4'(addr_i - slcd_pkg::OFF_DISP_MEM);
    // word accesses align down to the even byte, high byte first
    assign mem_even  = {mem_idx[3:1], 1'b0};
    assign mem_odd   = {mem_idx[3:1], 1'b1};
    assign mem_rd_hi = display_memory_q[mem_even];
    assign mem_rd_lo = (32'(mem_odd) < NB) ?
                       display_memory_q[mem_odd] : 8'h00;

    // readback, reserved bit four reads zero
    assign cfg_rd  = {duty_q, backplane_mirror_enable_q, 1'b0,
                      segment_group_select_q};
    assign ctrl_rd = {2'b00, disp_on_q, wave_b_q, freq_sel_q};

    // read mux, unmapped addresses read zero
    assign rd_d = hit_mem ? (word_i ? {mem_rd_hi, mem_rd_lo}
                                    : {8'h00, display_memory_q[mem_idx]})
                : hit_cfg   ? {8'h00, cfg_rd}
                : hit_ctrl  ? {8'h00, ctrl_rd}
                : hit_mstby ? {15'h0000, mstop_q}
                : 16'h0000;

    // read data stands only in the cycle after the strobe
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= rd_i ? rd_d : 16'h0000;
        end
    end

    // pin/duty configuration register, bit four dropped on write
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            duty_q <= slcd_pkg::RST_PIN_DUTY_CFG[7:6];
            backplane_mirror_enable_q <=
                slcd_pkg::RST_PIN_DUTY_CFG[slcd_pkg::MIRROR_POS];
            segment_group_select_q <= slcd_pkg::RST_PIN_DUTY_CFG[3:0];
        end else if (wr_i && hit_cfg) begin
            duty_q <= wdata_i[slcd_pkg::DUTY_HI_POS:slcd_pkg::DUTY_LO_POS];
            backplane_mirror_enable_q <= wdata_i[slcd_pkg::MIRROR_POS];
            segment_group_select_q <= wdata_i[slcd_pkg::SGS_MSB:0];
        end
    end

    // frame rate, waveform type, display on and module stop
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            freq_sel_q <= slcd_pkg::RST_DRIVE_CTRL[slcd_pkg::FREQ_MSB:0];
            wave_b_q   <= slcd_pkg::RST_DRIVE_CTRL[slcd_pkg::WAVE_B_POS];
            disp_on_q  <= slcd_pkg::RST_DRIVE_CTRL[slcd_pkg::DISP_ON_POS];
            mstop_q    <= slcd_pkg::RST_MOD_STANDBY[slcd_pkg::MSTOP_POS];
        end else begin
            if (wr_i && hit_ctrl) begin
                freq_sel_q <= wdata_i[slcd_pkg::FREQ_MSB:0];
                wave_b_q   <= wdata_i[slcd_pkg::WAVE_B_POS];
                disp_on_q  <= wdata_i[slcd_pkg::DISP_ON_POS];
            end
            if (wr_i && hit_mstby) begin
                mstop_q <= wdata_i[slcd_pkg::MSTOP_POS];
            end
        end
    end

    // display memory, one write enable per byte
    generate
        for (genvar k = 0; k < NB; k++) begin : g_mem
            localparam logic [3:0] KB = 4'(k);
            logic       we;
            logic [7:0] wd;
            assign we = wr_i && hit_mem &&
                        (word_i ? (mem_idx[3:1] == KB[3:1])
                                : (mem_idx == KB));
            assign wd = (word_i && !KB[0]) ? wdata_i[15:8] : wdata_i[7:0];
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    display_memory_q[k] <= slcd_pkg::RST_DISP_MEM;
                end else if (we) begin
                    display_memory_q[k] <= wd;
                end
            end
        end
    endgenerate

    // duty decode and run condition
    assign duty = slcd_pkg::slcd_duty_t'(duty_q);
    assign run  = disp_on_q && !standby_i && !mstop_q;

    // step-rate divider
    slcd_tick_if tick ();
    assign tick.run      = run;
    assign tick.freq_sel = freq_sel_q;

    slcd_frame_timer #(
        .CNT_W    (CNT_W),
        .DIV_BASE (DIV_BASE)
    ) u_timer (
        .mclk_i (mclk_i),
        .nrst_i (nrst_i),
        .tick   (tick.timer)
    );

    // last line of the frame is reached when line equals the duty code
    assign line_wrap = (line_q == duty_q);

    // line counter and drive polarity: A flips per line, B per frame
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_q <= 2'h0;
            pol_q  <= 1'b0;
        end else if (!run) begin
            line_q <= 2'h0;
            pol_q  <= 1'b0;
        end else if (tick.step) begin
            line_q <= line_wrap ? 2'h0 : line_q + 2'h1;
            if (!wave_b_q || line_wrap) begin
                pol_q <= !pol_q;
            end
        end
    end

    // common use and row for each pin: {used, row}
    function automatic logic [2:0] com_map(input logic [1:0] c,
                                           input slcd_pkg::slcd_duty_t d,
                                           input logic m);
        logic       used;
        logic [1:0] row;
        used = 1'b1;
        row  = c;
        unique case (d)
            slcd_pkg::DUTY_STATIC: begin
                used = (c == 2'h0) || m;
                row  = 2'h0;
            end
            slcd_pkg::DUTY_HALF: begin
                used = !c[1] || m;
                row  = m ? {1'b0, c[1]} : c;
            end
            slcd_pkg::DUTY_THIRD: begin
                used = (c != 2'h3);
                row  = c;
            end
            slcd_pkg::DUTY_QUARTER: begin
                used = 1'b1;
                row  = c;
            end
        endcase
        return {used, row};
    endfunction : com_map

    // common drive levels
    generate
        for (genvar c = 0; c < NC; c++) begin : g_com
            logic [2:0] map;
            logic       sel;
            logic [1:0] lvl;
            assign map = com_map(2'(c), duty, backplane_mirror_enable_q);
            assign sel = (map[1:0] == line_q);
            assign lvl = !(run && map[2]) ? slcd_pkg::LVL_VSS
                       : sel ? (pol_q ? slcd_pkg::LVL_V1 : slcd_pkg::LVL_VSS)
                       : (pol_q ? slcd_pkg::LVL_V3 : slcd_pkg::LVL_V2);
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    com_lvl_q[c]  <= slcd_pkg::LVL_VSS;
                    com_used_q[c] <= 1'b0;
                end else begin
                    com_lvl_q[c]  <= lvl;
                    com_used_q[c] <= map[2];
                end
            end
        end
    endgenerate

    // segment groups: seven groups, the top pin is group six
    generate
        for (genvar g = 0; g < slcd_pkg::NUM_GRP; g++) begin : g_grp
            localparam logic [3:0] GB = 4'(g);
            logic drv;
            // 1..8 add groups from the bottom, 9..14 drop them again
            assign drv = (segment_group_select_q == 4'h0 ||
                          segment_group_select_q == slcd_pkg::SGS_ALL_PORT)
                       ? 1'b0
                       : (segment_group_select_q <= slcd_pkg::SGS_ALL_DRV)
                       ? (GB < segment_group_select_q)
                       : (GB >= segment_group_select_q - 4'h8);
        end
    endgenerate

    // segment drive levels from display memory
    generate
        for (genvar s = 0; s < NS; s++) begin : g_seg
            localparam int GRP = s / 4;
            logic       drv;
            logic       on;
            logic [1:0] lvl;
            assign drv = g_grp[GRP].drv;
            assign on  = display_memory_q[s / 2][(s % 2) * 4 + line_q];
            assign lvl = !(run && drv) ? slcd_pkg::LVL_VSS
                       : on ? (pol_q ? slcd_pkg::LVL_VSS : slcd_pkg::LVL_V1)
                       : (duty == slcd_pkg::DUTY_STATIC)
                         ? (pol_q ? slcd_pkg::LVL_V1 : slcd_pkg::LVL_VSS)
                         : (pol_q ? slcd_pkg::LVL_V2 : slcd_pkg::LVL_V3);
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    seg_lvl_q[s] <= slcd_pkg::LVL_VSS;
                    seg_drv_q[s] <= 1'b0;
                end else begin
                    seg_lvl_q[s] <= lvl;
                    seg_drv_q[s] <= drv;
                end
            end
        end
    endgenerate

    // outputs straight from flip-flops
    assign rdata_o    = rdata_q;
    assign com_lvl_o  = com_lvl_q;
    assign com_used_o = com_used_q;
    assign seg_lvl_o  = seg_lvl_q;
    assign seg_drv_o  = seg_drv_q;
endmodule : slcd_top

// ==== slcd_top_assertions.sv ====
// port assertions for the segment lcd block
module slcd_top_assertions #(
    parameter int CNT_W    = 24, // divider width
    parameter int DIV_BASE = 6   // fastest divide
) (
    input wire logic             mclk_i,     // clock
    input wire logic             nrst_i,     // reset
    input wire logic [4:0]       addr_i,     // address
    input wire logic [15:0]      wdata_i,    // write data
    input wire logic             wr_i,       // write
    input wire logic             rd_i,       // read
    input wire logic             word_i,     // word
    input wire logic             standby_i,  // standby
    input wire logic [15:0]      rdata_o,    // read data
    input wire logic [3:0][1:0]  com_lvl_o,  // com levels
    input wire logic [3:0]       com_used_o, // com used
    input wire logic [24:0][1:0] seg_lvl_o,  // seg levels
    input wire logic [24:0]      seg_drv_o   // seg driver
);
    logic [7:0] cfg_q;    // config shadow
    logic [1:0] age_q;    // cycles since config write
    logic [1:0] dark_q;   // cycles with drive held off
    logic       on_q;     // display on shadow
    logic       stp_q;    // module stop shadow
    logic       warm_q;   // one edge past reset
    logic       lvl_ok;   // unused commons at level 0
    logic [3:0] used_exp; // expected commons
    logic [3:0] sgs;      // group select shadow
    logic       wcfg;     // config write
    logic       wdrv;     // drive control write
    logic       wstp;     // module stop write
    // decode of writes and expectations
    assign wcfg = wr_i && addr_i == slcd_pkg::OFF_PIN_DUTY_CFG;
    assign wdrv = wr_i && addr_i == slcd_pkg::OFF_DRIVE_CTRL;
    assign wstp = wr_i && addr_i == slcd_pkg::OFF_MOD_STANDBY;
    assign sgs  = cfg_q[3:0];
    assign used_exp = (cfg_q[7:6] == 2'h0) ? (cfg_q[5] ? 4'hf : 4'h1) :
                      (cfg_q[7:6] == 2'h1) ? (cfg_q[5] ? 4'hf : 4'h3) :
                      (cfg_q[7:6] == 2'h2) ? 4'h7 : 4'hf;
    // shadows of software state and settle counters
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_q  <= 8'h00;
            on_q   <= 1'b0;
            stp_q  <= 1'b0;
            warm_q <= 1'b0;
            age_q  <= 2'h0;
            dark_q <= 2'h0;
        end else begin
            warm_q <= 1'b1;
            cfg_q  <= wcfg ? wdata_i[7:0] : cfg_q;
            on_q   <= wdrv ? wdata_i[5] : on_q;
            stp_q  <= wstp ? wdata_i[0] : stp_q;
            age_q  <= wcfg ? 2'h0 : (age_q == 2'h3 ? age_q : age_q + 2'h1);
            dark_q <= !(standby_i || !on_q || stp_q) ? 2'h0 :
                      (dark_q == 2'h3 ? dark_q : dark_q + 2'h1);
        end
    end
    // unused commons must rest at level 0
    always_comb begin
        lvl_ok = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (!com_used_o[i] && com_lvl_o[i] != 2'h0) lvl_ok = 1'b0;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    property p_cfg_read; wcfg ##2 (rd_i && addr_i == 5'h00) |=>
        rdata_o == ($past(wdata_i, 3) & 16'h00ef); endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("config read back wrong");
    property p_com_used; warm_q |-> com_used_o == $past(used_exp); endproperty
    a_com_used: assert property (p_com_used)
        else $error("common use map wrong");
    property p_seg_all; warm_q && $past(sgs) == 4'h8 |-> &seg_drv_o; endproperty
    a_seg_all: assert property (p_seg_all)
        else $error("not all segments driving");
    property p_seg_none; warm_q && ($past(sgs) == 4'h0 ||
        $past(sgs) == 4'hf) |-> seg_drv_o == 25'h0; endproperty
    a_seg_none: assert property (p_seg_none)
        else $error("segments driving when all ports");
    property p_stat_mir; age_q == 2'h3 && cfg_q[7:5] == 3'h1 |->
        com_lvl_o == {4{com_lvl_o[0]}}; endproperty
    a_stat_mir: assert property (p_stat_mir)
        else $error("static mirror differs");
    property p_half_mir; age_q == 2'h3 && cfg_q[7:5] == 3'h3 |->
        com_lvl_o[3] == com_lvl_o[2] && com_lvl_o[1] == com_lvl_o[0];
    endproperty
    a_half_mir: assert property (p_half_mir)
        else $error("half mirror differs");
    property p_unused; age_q == 2'h3 |-> lvl_ok; endproperty
    a_unused: assert property (p_unused)
        else $error("unused common driven");
    property p_standby; standby_i [*2] |=>
        com_lvl_o == 8'h00 && seg_lvl_o == 50'h0; endproperty
    a_standby: assert property (p_standby)
        else $error("drive active in standby");
    property p_dark; dark_q == 2'h3 |-> com_lvl_o == 8'h00; endproperty
    a_dark: assert property (p_dark)
        else $error("drive active while stopped");
    property p_unmapped; rd_i && addr_i inside {[5'h03:5'h0f], [5'h1d:5'h1f]}
        |=> rdata_o == 16'h0000; endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    c_half_mir: cover property (age_q == 2'h3 && cfg_q[7:5] == 3'h3);
    c_standby: cover property (standby_i [*2]);
    c_word_rd: cover property (rd_i && word_i);
endmodule : slcd_top_assertions

bind slcd_top slcd_top_assertions #(.CNT_W(CNT_W), .DIV_BASE(DIV_BASE)) chk_u (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .word_i(word_i), .standby_i(standby_i),
    .rdata_o(rdata_o), .com_lvl_o(com_lvl_o), .com_used_o(com_used_o),
    .seg_lvl_o(seg_lvl_o), .seg_drv_o(seg_drv_o));

// ==== slcd_top_test.sv ====
// self-checking bench for the segment lcd block
module slcd_top_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0][3:0] USED = 32'hff77_f3f1; // commons per code
    logic mclk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic word_i = 1'b0, standby_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [15:0] wdata_i = 16'h0000, rdata_o, rd_v;
    logic [3:0][1:0] com_lvl_o;
    logic [3:0] com_used_o;
    logic [24:0][1:0] seg_lvl_o;
    logic [24:0] seg_drv_o;
    int errors = 0, samples_checked = 0, edges, gap, e0, ea, p;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    errors++; $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
    slcd_top #(.DIV_BASE(1)) dut_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .word_i(word_i), .standby_i(standby_i), .rdata_o(rdata_o),
        .com_lvl_o(com_lvl_o), .com_used_o(com_used_o),
        .seg_lvl_o(seg_lvl_o), .seg_drv_o(seg_drv_o));
    slcd_glass_model glass_u (.mclk_i(mclk_i), .nrst_i(nrst_i),
        .com_lvl_i(com_lvl_o), .seg_lvl_i(seg_lvl_o), .edges_o(edges),
        .gap_o(gap));
    // free-running system clock
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic bus_wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge mclk_i);
        wr_i    <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [4:0] a, input logic w);
        @(posedge mclk_i);
        addr_i <= a;
        word_i <= w;
        rd_i   <= 1'b1;
        @(posedge mclk_i);
        rd_i   <= 1'b0;
        word_i <= 1'b0;
        #1 rd_v = rdata_o;
    endtask : bus_rd
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : settle
    function automatic logic [24:0] seg_exp(input logic [3:0] c);
        logic [6:0] g;
        g = (c == 4'h0 || c == 4'hf) ? 7'h00 :
            (c < 4'h8) ? 7'h7f >> (4'h7 - c) : 7'h7f << (c - 4'h8);
        for (int i = 0; i < 24; i++) seg_exp[i] = g[i / 4];
        seg_exp[24] = g[6];
    endfunction : seg_exp
    task automatic t_duty;
        bus_rd(slcd_pkg::OFF_PIN_DUTY_CFG, 1'b0);
        `CHK("cfg_reset", 16'h0000, rd_v)
        `CHK("used_reset", 4'h1, com_used_o)
        for (int i = 0; i < 8; i++) begin
            bus_wr(slcd_pkg::OFF_PIN_DUTY_CFG, 16'(i << 5));
            settle(2);
            `CHK("com_used", USED[i], com_used_o)
        end
        bus_wr(slcd_pkg::OFF_PIN_DUTY_CFG, 16'h007b);
        bus_rd(slcd_pkg::OFF_PIN_DUTY_CFG, 1'b0);
        `CHK("cfg_back", 16'h006b, rd_v)
        $display("done duty");
    endtask : t_duty
    task automatic t_seg;
        for (int c = 0; c < 16; c++) begin
            bus_wr(slcd_pkg::OFF_PIN_DUTY_CFG, 16'(c));
            settle(2);
            `CHK("seg_drv", seg_exp(4'(c)), seg_drv_o)
        end
        $display("done segments");
    endtask : t_seg
    task automatic t_mem;
        for (int k = 0; k < 13; k++) begin
            bus_wr(5'(slcd_pkg::OFF_DISP_MEM + k), 16'(k * 17 + 12));
        end
        for (int k = 0; k < 13; k++) begin
            bus_rd(5'(slcd_pkg::OFF_DISP_MEM + k), 1'b0);
            `CHK("mem_byte", 16'(k * 17 + 12), rd_v)
        end
        @(posedge mclk_i) word_i <= 1'b1;
        bus_wr(5'h12, 16'hbeef);
        word_i <= 1'b0;
        bus_rd(5'h12, 1'b1);
        `CHK("mem_word", 16'hbeef, rd_v)
        bus_rd(5'h13, 1'b0);
        `CHK("mem_lo_byte", 16'h00ef, rd_v)
        bus_rd(5'h1d, 1'b0);
        `CHK("past_mem", 16'h0000, rd_v)
        $display("done memory");
    endtask : t_mem
    task automatic t_wave;
        bus_wr(slcd_pkg::OFF_PIN_DUTY_CFG, 16'h0028);
        bus_wr(slcd_pkg::OFF_DRIVE_CTRL, 16'h0020);
        settle(20);
        `CHK("static_mirror", com_lvl_o[0], com_lvl_o[3])
        `CHK("seg_on", com_lvl_o[0] ^ 2'h3, seg_lvl_o[2])
        `CHK("seg_off", com_lvl_o[0], seg_lvl_o[0])
        bus_wr(slcd_pkg::OFF_PIN_DUTY_CFG, 16'h0060);
        settle(20);
        `CHK("half_mirror", com_lvl_o[2], com_lvl_o[3])
        bus_wr(slcd_pkg::OFF_PIN_DUTY_CFG, 16'h00c0);
        e0 = edges;
        settle(64);
        ea = edges - e0;
        bus_wr(slcd_pkg::OFF_DRIVE_CTRL, 16'h0030);
        e0 = edges;
        settle(64);
        `CHK("wave_a_over_b", 1'b1, ea > edges - e0 + 12)
        for (int f = 0; f < 12; f++) begin
            p = 2 << ((f < 11) ? f : 10);
            bus_wr(slcd_pkg::OFF_DRIVE_CTRL, 16'((f < 11) ? 32 + f : 47));
            settle(3 * p + 8);
            `CHK("frame_gap", p, gap)
        end
        $display("done waveform");
    endtask : t_wave
    task automatic t_dark;
        bus_wr(slcd_pkg::OFF_DRIVE_CTRL, 16'h0020);
        standby_i <= 1'b1;
        settle(8);
        e0 = edges;
        settle(40);
        `CHK("standby_still", e0, edges)
        `CHK("standby_seg", 50'h0, seg_lvl_o)
        standby_i <= 1'b0;
        bus_wr(slcd_pkg::OFF_MOD_STANDBY, 16'h0001);
        settle(8);
        e0 = edges;
        settle(40);
        `CHK("stop_still", e0, edges)
        `CHK("stop_com", 8'h00, com_lvl_o)
        bus_wr(slcd_pkg::OFF_MOD_STANDBY, 16'h0000);
        settle(40);
        `CHK("resumed", 1'b1, edges > e0 + 4)
        $display("done standby");
    endtask : t_dark
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results
    // main sequence
    initial begin
        settle(8);
        nrst_i <= 1'b1;
        t_duty();
        t_seg();
        t_mem();
        t_wave();
        t_dark();
        results();
    end
    // hang guard, about four times the expected run
    initial begin
        #2_000_000;
        errors++;
        results();
    end
endmodule : slcd_top_test
